// file: design/port_io_pkg.sv
// Package: offsets, field positions, reset values and carriers for port block
package port_io_pkg;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h0E;
  localparam logic [7:0] COUNT_VALUE_ADDR   = 8'h0D;
  localparam logic [7:0] PORT_A_ADDR        = 8'h12;
  localparam logic [7:0] PORT_B_ADDR        = 8'h14;
  localparam int EDGE_SELECT_BIT   = 3;
  localparam int COUNT_RUN_BIT     = 4;
  localparam int CLOCK_SOURCE_BIT  = 5;
  localparam int MODE_LOW_BIT      = 6;
  localparam int MODE_HIGH_BIT     = 7;
  localparam int TONE_BIT0         = 0;
  localparam int TONE_BIT1         = 1;
  localparam int DIVIDER_BIT       = 3;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h08;
  localparam logic [7:0] TIMER_CONTROL_MASK  = 8'hF8;
  localparam logic [7:0] PORT_A_RESET        = 8'hFF;
  localparam logic [7:0] COUNT_MAX           = 8'hFF;
  localparam logic [1:0] SYSCLK_DIV          = 2'h3;
  typedef enum logic [1:0] {
    MODE_UNUSED = 2'b00,
    MODE_EVENT  = 2'b01,
    MODE_TIMER  = 2'b10,
    MODE_PULSE  = 2'b11
  } mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : port_io_pkg

// file: design/port_io_with_tone_and_divider.sv
// Ports A and B, timer control, counter, tone and divider outputs
// What this block does
// - Counter input clock is held off while software reads the count.
// - Timer control bits 2:0 always read as zero.
// - Event mode counts falling edges when edge select is 1, else rising.
// - Pulse mode counts between start and stop edges chosen by edge select.
// - Count run bit enables counting when set, disables when clear.
// - Clock source bit picks tick input at 0, system clock path at 1.
// - Mode field: 01 event, 10 timer, 11 pulse width, 00 unused.
// - Port A sits at data address 12H, port B at 14H.
// - Port A bits 3:0 optionally push-pull; bits 7:4 open-drain pull-up.
// - Each open-drain port A pin can be enabled as a halt wake source.
// - Port reads sample the pin levels directly, not latched.
// - Port A writes go to an output latch held until rewritten.
// - Bit operations read pin states, modify, write back to the latch.
// - Reading port A returns pin levels, not latch content.
// - Push-pull port A pins act only as outputs.
// - Latch bits 1:0 steer tone pair: 00 both, 10 tone only, x1 low.
// - Pin 3 carries divider when running and latch bit 3 is 0.
// - After reset the port inputs sit high or float by pull-up option.
// - Counter counts up to FFH, reloads from preload, raises request.
// - Overflow can feed divider on pin 3 and wakes from halt.
module port_io_with_tone_and_divider #(
  parameter logic [3:0] PUSH_PULL_OPT  = 4'h0,
  parameter logic [3:0] PULLUP_OPT     = 4'hF,
  parameter logic       TONE_OPT       = 1'b0,
  parameter logic       DIVIDER_OPT    = 1'b0,
  parameter logic       SYSCLK_DIV4    = 1'b0
) (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire port_io_pkg::mem_req_t     req_i,
  output logic [7:0]                     rdata_o,
  input  wire logic [7:0]                port_a_in_i,
  output logic [7:0]                     port_a_out_o,
  output logic [7:0]                     port_a_oe_o,
  output logic [7:0]                     port_a_pullup_o,
  input  wire logic [5:0]                port_b_in_i,
  input  wire logic                      count_pin_i,
  input  wire logic                      rtc_tick_i,
  input  wire logic                      tone_i,
  input  wire logic [7:0]                wake_enable_i,
  input  wire logic                      halted_i,
  output logic                           wake_o,
  output logic                           overflow_flag_o
);
  logic [7:0]  timer_control;
  logic [7:0]  port_a_latch;
  logic [7:0]  preload;
  logic [7:0]  count_value;
  logic [7:0]  pa_s1, pa_s2, pa_s3, pa_pin;
  logic [5:0]  pb_s1, pb_s2, pb_s3, pb_held, pb_pin;
  logic [2:0]  cp_s;
  logic [7:0]  pa_prev;
  logic [1:0]  div_cnt;
  logic        divider_out, cp_held, cp_pin;
  logic        pulse_active;
  logic        sys_tick, ext_rise, ext_fall, int_tick, count_en, ovf;
  logic        reading_count, wr_ctrl, wr_count;
  logic        tone_en0, tone_en1, div_en;
  logic [7:0]  next_latch, pa_fall;
  port_io_pkg::mode_t mode;

  assign mode = port_io_pkg::mode_t'(timer_control[
    port_io_pkg::MODE_HIGH_BIT:port_io_pkg::MODE_LOW_BIT]);
  assign reading_count = req_i.rd
    && req_i.addr == port_io_pkg::COUNT_VALUE_ADDR;
  assign wr_ctrl  = req_i.wr && req_i.addr == port_io_pkg::TIMER_CONTROL_ADDR;
  assign wr_count = req_i.wr && req_i.addr == port_io_pkg::COUNT_VALUE_ADDR;

  // Three-stage pin sampling; a level counts once stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_s1 <= 8'hFF;
      pa_s2 <= 8'hFF;
      pa_s3 <= 8'hFF;
      pa_prev <= 8'hFF;
      pb_s1 <= 6'h3F;
      pb_s2 <= 6'h3F;
      pb_s3 <= 6'h3F;
      pb_held <= 6'h3F;
      cp_s  <= 3'h0;
      cp_held <= 1'b0;
    end else begin
      pa_s1 <= port_a_in_i;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pb_s1 <= port_b_in_i;
      pb_s2 <= pb_s1;
      pb_s3 <= pb_s2;
      pa_prev <= pa_pin;
      pb_held <= pb_pin;
      cp_s  <= {cp_s[1:0], count_pin_i};
      cp_held <= cp_pin;
    end
  end

  assign pa_pin = (pa_s2 & pa_s3) | (pa_prev & (pa_s2 | pa_s3));
  assign pb_pin = (pb_s2 & pb_s3) | (pb_held & (pb_s2 | pb_s3));
  assign cp_pin = (cp_s[1] & cp_s[2]) | (cp_held & (cp_s[1] | cp_s[2]));
  assign ext_rise = cp_pin && !cp_held;
  assign ext_fall = !cp_pin && cp_held;

  // System clock path, optionally divided by four
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign sys_tick = SYSCLK_DIV4 ? (div_cnt == port_io_pkg::SYSCLK_DIV) : 1'b1;
  assign int_tick = timer_control[port_io_pkg::CLOCK_SOURCE_BIT]
                  ? sys_tick : rtc_tick_i;

  always_comb begin
    count_en = 1'b0;
    if (timer_control[port_io_pkg::COUNT_RUN_BIT] && !reading_count) begin
      case (mode)
        port_io_pkg::MODE_EVENT: count_en =
          timer_control[port_io_pkg::EDGE_SELECT_BIT] ? ext_fall : ext_rise;
        port_io_pkg::MODE_TIMER: count_en = int_tick;
        port_io_pkg::MODE_PULSE: count_en = pulse_active && int_tick;
        default: count_en = 1'b0;
      endcase
    end
  end
  assign ovf = count_en && count_value == port_io_pkg::COUNT_MAX;

  // Pulse window: start and stop edges chosen by edge select
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_active <= 1'b0;
    end else if (mode != port_io_pkg::MODE_PULSE
                 || !timer_control[port_io_pkg::COUNT_RUN_BIT]) begin
      pulse_active <= 1'b0;
    end else if (timer_control[port_io_pkg::EDGE_SELECT_BIT]) begin
      if (ext_rise) pulse_active <= 1'b1;
      else if (ext_fall && pulse_active) pulse_active <= 1'b0;
    end else begin
      if (ext_fall) pulse_active <= 1'b1;
      else if (ext_rise && pulse_active) pulse_active <= 1'b0;
    end
  end

  // Timer control register; run clears itself after a pulse measurement
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_control <= port_io_pkg::TIMER_CONTROL_RESET;
    end else if (wr_ctrl) begin
      timer_control <= req_i.wdata & port_io_pkg::TIMER_CONTROL_MASK;
    end else if (mode == port_io_pkg::MODE_PULSE && pulse_active
                 && (timer_control[port_io_pkg::EDGE_SELECT_BIT]
                     ? ext_fall : ext_rise)) begin
      timer_control[port_io_pkg::COUNT_RUN_BIT] <= 1'b0;
    end
  end

  // Preload and running count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preload <= 8'h00;
    end else if (wr_count) begin
      preload <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_value <= 8'h00;
    end else if (wr_count && !timer_control[port_io_pkg::COUNT_RUN_BIT]) begin
      count_value <= req_i.wdata;
    end else if (ovf) begin
      count_value <= preload;
    end else if (count_en) begin
      count_value <= count_value + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overflow_flag_o <= 1'b0;
    end else begin
      overflow_flag_o <= ovf;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      divider_out <= 1'b0;
    end else if (ovf) begin
      divider_out <= !divider_out;
    end
  end

  // Bit operations pass pin states in wdata; latch keeps until rewritten
  always_comb begin
    next_latch = port_a_latch;
    if (req_i.wr && req_i.addr == port_io_pkg::PORT_A_ADDR) begin
      next_latch = req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_a_latch <= port_io_pkg::PORT_A_RESET;
    end else begin
      port_a_latch <= next_latch;
    end
  end

  // Read data: ports return pin levels straight from the sampler
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      if (req_i.addr == port_io_pkg::PORT_A_ADDR) begin
        rdata_o <= pa_pin;
      end else if (req_i.addr == port_io_pkg::PORT_B_ADDR) begin
        rdata_o <= {2'b00, pb_pin};
      end else if (req_i.addr == port_io_pkg::TIMER_CONTROL_ADDR) begin
        rdata_o <= timer_control & port_io_pkg::TIMER_CONTROL_MASK;
      end else if (req_i.addr == port_io_pkg::COUNT_VALUE_ADDR) begin
        rdata_o <= count_value;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  localparam logic [7:0] PUSH_PULL_ALL = {4'h0, PUSH_PULL_OPT};
  localparam logic [7:0] PULLUP_ALL    = {4'hF, PULLUP_OPT} & ~PUSH_PULL_ALL;
  assign tone_en0 = TONE_OPT && PUSH_PULL_OPT[0];
  assign tone_en1 = TONE_OPT && PUSH_PULL_OPT[1];
  assign div_en   = DIVIDER_OPT && PUSH_PULL_OPT[3];

  // Pin drivers: push-pull low nibble or open-drain pull-down
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (PUSH_PULL_ALL[i]) begin
        port_a_out_o[i] = port_a_latch[i];
        port_a_oe_o[i]  = 1'b1;
      end else begin
        port_a_out_o[i] = 1'b0;
        port_a_oe_o[i]  = !port_a_latch[i];
      end
      port_a_pullup_o[i] = PULLUP_ALL[i];
    end
    if (tone_en0) begin
      port_a_out_o[port_io_pkg::TONE_BIT0] =
        !port_a_latch[port_io_pkg::TONE_BIT0] && tone_i;
    end
    if (tone_en1) begin
      port_a_out_o[port_io_pkg::TONE_BIT1] =
        !port_a_latch[port_io_pkg::TONE_BIT0]
        && !port_a_latch[port_io_pkg::TONE_BIT1] && !tone_i;
    end
    if (div_en) begin
      port_a_out_o[port_io_pkg::DIVIDER_BIT] =
        !port_a_latch[port_io_pkg::DIVIDER_BIT] && divider_out;
    end
  end

  // Wake on falling edge of enabled open-drain pins or overflow
  assign pa_fall = pa_prev & ~pa_pin & wake_enable_i
                 & ~PUSH_PULL_ALL;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= halted_i && (|pa_fall || ovf);
    end
  end

  property p_ctrl_low_zero;
    @(posedge clk_i) disable iff (!resetn_i)
      timer_control[2:0] == 3'h0;
  endproperty
  a_ctrl_low_zero: assert property (p_ctrl_low_zero)
    else $error("control low bits not zero");

  property p_read_blocks;
    @(posedge clk_i) disable iff (!resetn_i)
      reading_count |=> $stable(count_value) || $past(wr_count);
  endproperty
  a_read_blocks: assert property (p_read_blocks)
    else $error("count moved during read");

  property p_reload;
    @(posedge clk_i) disable iff (!resetn_i)
      ovf && !wr_count |=> count_value == $past(preload) && overflow_flag_o;
  endproperty
  a_reload: assert property (p_reload)
    else $error("overflow did not reload");

  property p_div_toggle;
    @(posedge clk_i) disable iff (!resetn_i)
      ovf |=> divider_out != $past(divider_out);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divider did not toggle");

  property p_run_off;
    @(posedge clk_i) disable iff (!resetn_i)
      !timer_control[port_io_pkg::COUNT_RUN_BIT] |-> !count_en;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("counted while stopped");

  property p_latch_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      !(req_i.wr && req_i.addr == port_io_pkg::PORT_A_ADDR)
      |=> $stable(port_a_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without write");

  property p_pa_read;
    @(posedge clk_i) disable iff (!resetn_i)
      req_i.rd && req_i.addr == port_io_pkg::PORT_A_ADDR
      |=> rdata_o == $past(pa_pin);
  endproperty
  a_pa_read: assert property (p_pa_read)
    else $error("port A read not pin level");

  property p_event_edge;
    @(posedge clk_i) disable iff (!resetn_i)
      mode == port_io_pkg::MODE_EVENT && count_en
      |-> (timer_control[port_io_pkg::EDGE_SELECT_BIT] ? ext_fall : ext_rise);
  endproperty
  a_event_edge: assert property (p_event_edge)
    else $error("event counted on wrong edge");
endmodule : port_io_with_tone_and_divider

// file: testbench/pin_side_model.sv
// Pin-side model: resolves port A pads from drive, pull-up and load
module pin_side_model (
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pad_o
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) begin
        pad_o[i] = out_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else begin
        // Floating pad shows no stale level
        pad_o[i] = pullup_i[i] ? 1'b1 : ~out_i[i];
      end
    end
  end
endmodule : pin_side_model

// file: testbench/port_io_with_tone_and_divider_tb.sv
// Self-checking bench for the port, tone and divider block
module port_io_with_tone_and_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, rstn, tone, cpin, tick, halt, d0;
  port_io_pkg::mem_req_t req;
  logic [7:0]            rdata, aout, aoe, apu, ev, ee, wen, pad, d;
  logic [5:0]            pb;
  logic                  wake, ovf;
  int                    error_cnt, total_checks, cyc, n;

  port_io_with_tone_and_divider #(
    .PUSH_PULL_OPT(4'hB), .TONE_OPT(1'b1), .DIVIDER_OPT(1'b1)
  ) u_dut (
    .clk_i(clk), .resetn_i(rstn), .req_i(req), .rdata_o(rdata),
    .port_a_in_i(pad), .port_a_out_o(aout), .port_a_oe_o(aoe),
    .port_a_pullup_o(apu), .port_b_in_i(pb), .count_pin_i(cpin),
    .rtc_tick_i(tick), .tone_i(tone), .wake_enable_i(wen),
    .halted_i(halt), .wake_o(wake), .overflow_flag_o(ovf));
  pin_side_model u_pins (.out_i(aout), .oe_i(aoe), .pullup_i(apu),
    .ext_val_i(ev), .ext_en_i(ee), .pad_o(pad));

  function automatic logic [7:0] exp_pad(logic [7:0] lat, logic [7:0] v,
                                         logic [7:0] e, logic t);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 2; i < 8; i++) begin
      if (i != 3) r[i] = lat[i] ? (e[i] ? v[i] : 1'b1) : 1'b0;
    end
    r[0] = !lat[0] & t;
    r[1] = (lat[1:0] == 2'b00) & !t;
    return r;
  endfunction : exp_pad

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rchk

  // Cycles between two divider toggles or two overflow pulses
  task automatic gap(input bit sel, output int cnt);
    logic p, q;
    int   k;
    k = 0;
    cnt = 0;
    p = sel ? ovf : pad[3];
    while (k < 2 && cnt < 1000) begin
      @(posedge clk);
      #1 q = sel ? ovf : pad[3];
      cnt++;
      if (sel ? (q & !p) : (q != p)) begin
        k++;
        if (k == 1) cnt = 0;
      end
      p = q;
    end
  endtask : gap

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    rstn = 1'b0; req = '0; tone = 1'b0; cpin = 1'b0; tick = 1'b0;
    halt = 1'b0; ev = 8'h00; ee = 8'h00; wen = 8'h00; pb = 6'h00;
    void'($urandom(32'hF3A3));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rchk(8'h0E, 8'h08);
    chk(apu, 8'hF4);
    rchk(8'h12, exp_pad(8'hFF, 8'h00, 8'h00, 1'b0));
    rchk(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'hEF;
      wr(8'h0E, d);
      rchk(8'h0E, d & 8'hF8);
    end
    for (int i = 0; i < 12; i++) begin
      d = (8'($urandom) & 8'hFC) | 8'h08 | 8'(i % 4);
      ev <= 8'($urandom); ee <= 8'($urandom) & 8'hF4;
      tone <= 1'($urandom); pb <= 6'($urandom);
      wr(8'h12, d);
      repeat (4) @(posedge clk);
      rchk(8'h12, exp_pad(d, ev, ee, tone));
      rchk(8'h14, {2'b00, pb});
    end
    wr(8'h12, 8'hFF);
    ee <= 8'h20; ev <= 8'h00; tone <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h12, d);
    wr(8'h12, d & 8'hFB);
    ee <= 8'h00;
    repeat (4) @(posedge clk);
    rchk(8'h12, exp_pad(8'hD0, 8'h00, 8'h00, 1'b0));
    wr(8'h0E, 8'h90);
    wr(8'h0E, 8'h00);
    for (int e = 0; e < 2; e++) begin
      cpin <= 1'b0;
      wr(8'h0D, 8'h10);
      wr(8'h0E, {4'h5, e[0], 3'b000});
      for (int k = 0; k < 3; k++) begin
        repeat (4) @(posedge clk);
        cpin <= ~cpin;
      end
      repeat (4) @(posedge clk);
      rchk(8'h0D, e[0] ? 8'h11 : 8'h12);
      wr(8'h0E, 8'h00);
      cpin <= 1'b0;
      repeat (4) @(posedge clk);
      cpin <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(8'h0D, e[0] ? 8'h11 : 8'h12);
    end
    wr(8'h0D, 8'h20);
    wr(8'h0E, 8'h90);
    repeat (5) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    rchk(8'h0D, 8'h25);
    @(posedge clk) begin
      tick <= 1'b1;
      req  <= '{1'b0, 1'b1, 8'h0D, 8'h00};
    end
    @(posedge clk) begin
      tick <= 1'b0;
      req  <= '0;
    end
    rchk(8'h0D, 8'h25);
    for (int e = 0; e < 2; e++) begin
      cpin <= ~e[0];
      wr(8'h0E, 8'h00);
      wr(8'h0D, 8'h00);
      wr(8'h0E, {4'hF, e[0], 3'b000});
      repeat (4) @(posedge clk);
      cpin <= e[0];
      repeat (20) @(posedge clk);
      cpin <= ~e[0];
      repeat (6) @(posedge clk);
      rd(8'h0D, d);
      chk({7'h00, d >= 8'd19 && d <= 8'd21}, 8'h01);
      rd(8'h0E, d);
      chk(d & 8'h10, 8'h00);
    end
    wr(8'h0E, 8'h00);
    wr(8'h0D, 8'hF0);
    wr(8'h12, 8'hF7);
    wr(8'h0E, 8'hB0);
    gap(1'b0, n);
    chk(8'(n), 8'h10);
    gap(1'b1, n);
    chk(8'(n), 8'h10);
    wr(8'h0E, 8'h00);
    wr(8'h12, 8'hFF);
    halt <= 1'b1; wen <= 8'h80; ee <= 8'h80; ev <= 8'h80;
    repeat (4) @(posedge clk);
    ev <= 8'h00;
    d0 = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1 d0 |= wake;
    end
    chk({7'h00, d0}, 8'h01);
    ev <= 8'h80; wen <= 8'h00;
    repeat (4) @(posedge clk);
    ev <= 8'h00;
    d0 = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1 d0 |= wake;
    end
    chk({7'h00, d0}, 8'h00);
    tally_and_finish();
  end
endmodule : port_io_with_tone_and_divider_tb
